//--- include/dac_cfg_defs.svh
// Purpose: named offsets, field positions, reset values and counts
// Assumes: included by its bare name
// Notes: register indices are the printed control word indices
`ifndef DAC_CFG_DEFS_SVH
`define DAC_CFG_DEFS_SVH
`define IDX_MUTE_CTL    7'h08
`define IDX_FORMAT      7'h09
`define IDX_DEEMPH      7'h0A
`define IDX_READBACK    7'h0B
`define IDX_GPO         7'h0C
`define IDX_FIRST       7'h01
`define IDX_STEP        7'h01
`define RD_INDEX_RST    7'h01
`define BYTE_ZERO       8'h00
`define SILENCE_MUTE_ENABLE_BIT        6
`define FMT_MSB         2
`define DM_MSB          2
`define DMF_MSB         4
`define DMF_LSB         3
`define REV_BIT         5
`define DEEMPH_MSB      5
`define INC_BIT         7
`define RDIDX_MSB       6
`define OVER_BIT        7
`define GP_OUT_ENABLE_BIT        6
`define GPO_MSB         5
`define WORD_LAST_BIT   4'hF
`define SILENCE_CNT_W   11
`define SILENCE_PERIODS 11'h400
`define SILENCE_STEP    11'h001
`endif

//--- include/dac_cfg_pkg.sv
// Purpose: shared types of the DAC control register block
// Assumes: nothing
// Notes: reserved codes are kept as written
package dac_cfg_pkg;
  typedef enum logic [2:0] {
    FMT_RJ24 = 3'h0, FMT_RJ20 = 3'h1, FMT_RJ18 = 3'h2, FMT_RJ16 = 3'h3,
    FMT_I2S  = 3'h4, FMT_LJ   = 3'h5, FMT_RSV6 = 3'h6, FMT_RSV7 = 3'h7
  } audio_format_type;
  typedef enum logic [1:0] {
    DEEMPH_44K1 = 2'h0, DEEMPH_48K = 2'h1, DEEMPH_32K = 2'h2, DEEMPH_RSV = 2'h3
  } deemph_rate_type;
  typedef struct packed {
    audio_format_type audio_format_sel;
    deemph_rate_type  deemph_rate_sel;
    logic             deemph_en_pair_c;
    logic             deemph_en_pair_b;
    logic             deemph_en_pair_a;
    logic             output_invert;
    logic             oversample_sel;
  } dac_cfg_type;
  typedef struct packed {
    logic       rw;
    logic [6:0] word_index_field;
    logic [7:0] data;
  } ctrl_word_type;
  typedef enum {RD_IDLE, RD_SEND} read_state_type;
endpackage

//--- verilog/serial_word_port.sv
// Purpose: bit level side of the 4-wire control port
// Assumes: control clock high and low phases of at least 4 clk_sys_i cycles
// Notes: all pins pass two flip-flops before use
`timescale 1ns/1ps
`include "dac_cfg_defs.svh"
module serial_word_port
  import dac_cfg_pkg::*;
(
  input  wire logic    clk_sys_i,
  input  wire logic    rst_n_i,
  input  wire logic    ctrl_sel_b_i,
  input  wire logic    ctrl_clk_i,
  input  wire logic    ctrl_din_i,
  input  wire logic    load_i,
  input  ctrl_word_type load_word_i,
  output logic         word_tick_o,
  output ctrl_word_type word_o,
  output logic         frame_end_o,
  output logic         dout_o
);
  logic [2:0]  pin_meta;
  logic [2:0]  pin_sync;
  logic        clk_prev;
  logic        sel_prev;
  logic [3:0]  bit_cnt;
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic        rise;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      clk_prev <= 1'b0;
      sel_prev <= 1'b1;
    end else begin
      pin_meta <= {ctrl_sel_b_i, ctrl_clk_i, ctrl_din_i};
      pin_sync <= pin_meta;
      clk_prev <= pin_sync[1];
      sel_prev <= pin_sync[2];
    end
  end

  assign rise = pin_sync[1] & ~clk_prev & ~pin_sync[2];

  // words are taken most significant bit first, one per 16 rising edges
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt     <= 4'h0;
      shift_in    <= 16'h0000;
      word_tick_o <= 1'b0;
      word_o      <= '0;
      frame_end_o <= 1'b0;
    end else begin
      word_tick_o <= rise && (bit_cnt == `WORD_LAST_BIT);
      frame_end_o <= pin_sync[2] & ~sel_prev;
      if (pin_sync[2]) begin
        bit_cnt <= 4'h0;
      end else if (rise) begin
        bit_cnt  <= bit_cnt + 4'h1;
        shift_in <= {shift_in[14:0], pin_sync[0]};
        if (bit_cnt == `WORD_LAST_BIT) begin
          word_o <= {shift_in[14:0], pin_sync[0]};
        end
      end
    end
  end

  // read data moves on after the host has sampled it at a rising edge
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_out <= 16'h0000;
    end else if (load_i) begin
      shift_out <= load_word_i;
    end else if (pin_sync[2]) begin
      shift_out <= 16'h0000;
    end else if (rise) begin
      shift_out <= {shift_out[14:0], 1'b0};
    end
  end

  assign dout_o = shift_out[15];
endmodule

//--- verilog/silence_detect.sv
// Purpose: per channel run length of all-zero samples
// Assumes: strobe and zero flags come from logic on clk_sys_i
// Notes: one detector feeds both the flag pins and the mute
`timescale 1ns/1ps
`include "dac_cfg_defs.svh"
module silence_detect
  import dac_cfg_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       sample_strobe_i,
  input  wire logic [5:0] sample_zero_i,
  input  wire logic       disable_i,
  output logic      [5:0] chan_silence_flag_o
);
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : chan
      logic [`SILENCE_CNT_W-1:0] run;

      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          run <= '0;
        end else if (disable_i) begin
          run <= '0;
        end else if (sample_strobe_i) begin
          if (!sample_zero_i[g]) begin
            run <= '0;
          end else if (run != `SILENCE_PERIODS) begin
            run <= run + `SILENCE_STEP;
          end
        end
      end

      assign chan_silence_flag_o[g] = (run == `SILENCE_PERIODS);

      sequence last_zero_sample;
        sample_strobe_i && sample_zero_i[g] && !disable_i
          && (run == `SILENCE_PERIODS - `SILENCE_STEP);
      endsequence
      flag_count_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        last_zero_sample |=> chan_silence_flag_o[g])
        else $error("silence flag missing after 1024 zero samples");
      flag_early_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(chan_silence_flag_o[g]) |-> $past(sample_strobe_i && sample_zero_i[g]
          && !disable_i && (run == `SILENCE_PERIODS - `SILENCE_STEP)))
        else $error("silence flag rose without 1024 zero samples");
    end
  endgenerate
endmodule

//--- verilog/dac_config_registers.sv
// Purpose: control registers of a six channel audio DAC
// Assumes: serial control port pins and a same-clock sample strobe
// Notes: indices 8 to 12 are held here, other indices read as zero
`timescale 1ns/1ps
`include "dac_cfg_defs.svh"
module dac_config_registers
  import dac_cfg_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       ctrl_sel_b_i,
  input  wire logic       ctrl_clk_i,
  input  wire logic       ctrl_din_i,
  input  wire logic       sample_strobe_i,
  input  wire logic [5:0] sample_zero_i,
  output logic            ctrl_dout_o,
  output dac_cfg_type     dac_cfg_o,
  output logic      [5:0] gp_pin_o,
  output logic            all_silence_flag_o,
  output logic      [5:0] mute_to_midscale_o
);
  logic           rst_meta;
  logic           rst_n;
  logic           word_tick;
  ctrl_word_type  word;
  logic           frame_end;
  logic           load;
  ctrl_word_type  load_word;
  read_state_type state;
  logic [6:0]     cur_idx;
  logic [6:0]     next_idx;
  logic           wr_en;
  logic           rd_start;
  logic           more;
  logic [5:0]     flags;

  // control registers
  logic           silence_mute_enable;
  logic [2:0]     reg_format;
  logic [5:0]     reg_deemph;
  logic [7:0]     reg_readback;
  logic [7:0]     reg_gpo;

  logic           auto_inc;
  logic [6:0]     rd_idx;
  logic           gp_out_enable;
  logic [5:0]     gp_out_bit;

  assign auto_inc      = reg_readback[`INC_BIT];
  assign rd_idx        = reg_readback[`RDIDX_MSB:0];
  assign gp_out_enable = reg_gpo[`GP_OUT_ENABLE_BIT];
  assign gp_out_bit    = reg_gpo[`GPO_MSB:0];

  // reset release is synchronised, assertion stays asynchronous
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  serial_word_port u_port (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n),
    .ctrl_sel_b_i(ctrl_sel_b_i),
    .ctrl_clk_i  (ctrl_clk_i),
    .ctrl_din_i  (ctrl_din_i),
    .load_i      (load),
    .load_word_i (load_word),
    .word_tick_o (word_tick),
    .word_o      (word),
    .frame_end_o (frame_end),
    .dout_o      (ctrl_dout_o)
  );

  silence_detect u_silence (
    .clk_sys_i          (clk_sys_i),
    .rst_n_i            (rst_n),
    .sample_strobe_i    (sample_strobe_i),
    .sample_zero_i      (sample_zero_i),
    .disable_i          (reg_deemph[`REV_BIT]),
    .chan_silence_flag_o(flags)
  );

  function automatic logic [7:0] reg_read(input logic [6:0] idx);
    logic [7:0] value;
    value = `BYTE_ZERO;
    case (idx)
      `IDX_MUTE_CTL: value[`SILENCE_MUTE_ENABLE_BIT] = silence_mute_enable;
      `IDX_FORMAT:   value[`FMT_MSB:0] = reg_format;
      `IDX_DEEMPH:   value[`DEEMPH_MSB:0] = reg_deemph;
      `IDX_READBACK: value = reg_readback;
      `IDX_GPO:      value = reg_gpo;
      default:       value = `BYTE_ZERO;
    endcase
    return value;
  endfunction

  // a word is a write only when no read answer is in progress
  assign wr_en    = word_tick && (state == RD_IDLE) && !word.rw;
  assign rd_start = word_tick && (state == RD_IDLE) && word.rw;
  assign next_idx = cur_idx + `IDX_STEP;
  assign more     = auto_inc && (cur_idx < rd_idx);

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      silence_mute_enable <= 1'b0;
    end else if (wr_en && word.word_index_field == `IDX_MUTE_CTL) begin
      silence_mute_enable <= word.data[`SILENCE_MUTE_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_format <= FMT_RJ24;
    end else if (wr_en && word.word_index_field == `IDX_FORMAT) begin
      reg_format <= word.data[`FMT_MSB:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_deemph <= 6'h00;
    end else if (wr_en && word.word_index_field == `IDX_DEEMPH) begin
      reg_deemph <= word.data[`DEEMPH_MSB:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_readback <= {1'b0, `RD_INDEX_RST};
    end else if (wr_en && word.word_index_field == `IDX_READBACK) begin
      reg_readback <= word.data;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_gpo <= `BYTE_ZERO;
    end else if (wr_en && word.word_index_field == `IDX_GPO) begin
      reg_gpo <= word.data;
    end
  end

  assign dac_cfg_o.audio_format_sel = audio_format_type'(reg_format);
  assign dac_cfg_o.deemph_rate_sel  =
    deemph_rate_type'(reg_deemph[`DMF_MSB:`DMF_LSB]);
  assign dac_cfg_o.deemph_en_pair_c = reg_deemph[2];
  assign dac_cfg_o.deemph_en_pair_b = reg_deemph[1];
  assign dac_cfg_o.deemph_en_pair_a = reg_deemph[0];
  assign dac_cfg_o.output_invert    = reg_deemph[`REV_BIT];
  assign dac_cfg_o.oversample_sel   = reg_gpo[`OVER_BIT];

  // read answers go out as whole words in the same frame, from the word after the command
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state     <= RD_IDLE;
      cur_idx   <= `IDX_FIRST;
      load      <= 1'b0;
      load_word <= '0;
    end else if (frame_end) begin
      state <= RD_IDLE;
      load  <= 1'b0;
    end else begin
      load <= 1'b0;
      case (state)
        RD_IDLE: begin
          if (rd_start) begin
            state <= RD_SEND;
            load  <= 1'b1;
            if (auto_inc) begin
              cur_idx   <= `IDX_FIRST;
              load_word <= {1'b1, `IDX_FIRST, reg_read(`IDX_FIRST)};
            end else begin
              cur_idx   <= rd_idx;
              load_word <= {1'b1, rd_idx, reg_read(rd_idx)};
            end
          end
        end
        RD_SEND: begin
          if (word_tick) begin
            if (more) begin
              cur_idx   <= next_idx;
              load_word <= {1'b1, next_idx, reg_read(next_idx)};
              load      <= 1'b1;
            end else begin
              state <= RD_IDLE;
            end
          end
        end
        default: begin
          state <= RD_IDLE;
        end
      endcase
    end
  end

  // one detector result drives pins, combined flag and mute alike
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      gp_pin_o           <= 6'h00;
      all_silence_flag_o <= 1'b0;
      mute_to_midscale_o <= 6'h00;
    end else begin
      gp_pin_o           <= gp_out_enable ? gp_out_bit : flags;
      all_silence_flag_o <= &flags;
      mute_to_midscale_o <= {6{silence_mute_enable}} & flags;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n);

  sequence wr_to(logic [6:0] idx);
    wr_en && (word.word_index_field == idx);
  endsequence

  sequence gp_enabled_write;
    wr_en && (word.word_index_field == `IDX_GPO) && word.data[`GP_OUT_ENABLE_BIT];
  endsequence

  sequence last_word_sent;
    (state == RD_SEND) && word_tick && !more;
  endsequence

  fmt_write_a: assert property (
    wr_to(`IDX_FORMAT) |=> reg_format == $past(word.data[2:0]))
    else $error("format field did not take written code");

  deemph_write_a: assert property (
    wr_to(`IDX_DEEMPH) |=>
      {dac_cfg_o.output_invert, dac_cfg_o.deemph_rate_sel,
       dac_cfg_o.deemph_en_pair_c, dac_cfg_o.deemph_en_pair_b,
       dac_cfg_o.deemph_en_pair_a} == $past(word.data[5:0]))
    else $error("de-emphasis and invert fields wrong after write");

  invert_kills_a: assert property (
    dac_cfg_o.output_invert [*2] |-> (flags == 6'h00) ##1 !all_silence_flag_o)
    else $error("zero detect still active while inverted");

  auto_start_a: assert property (
    rd_start && auto_inc |=> load && (cur_idx == `IDX_FIRST))
    else $error("auto read did not start at first register");

  single_read_a: assert property (
    rd_start && !auto_inc |=>
      load && (load_word.word_index_field == $past(rd_idx))
      && (load_word.data == reg_read($past(rd_idx))))
    else $error("single read returned wrong register");

  auto_stop_a: assert property (
    last_word_sent and !frame_end |=> (state == RD_IDLE) && !load)
    else $error("read sequence ran past last index");

  gp_drive_a: assert property (
    gp_enabled_write ##1 !(wr_en && (word.word_index_field == `IDX_GPO)) |=>
      gp_pin_o == $past(word.data[5:0], 2))
    else $error("pins do not show general-purpose bits");

  zero_pins_a: assert property (
    !gp_out_enable ##1 !gp_out_enable |-> gp_pin_o == $past(flags))
    else $error("pins do not carry zero flags");

  over_write_a: assert property (
    wr_to(`IDX_GPO) |=> dac_cfg_o.oversample_sel == $past(word.data[7]))
    else $error("oversampling select not stored");

  read_keeps_a: assert property (
    word_tick && word.rw |=> $stable(reg_gpo) && $stable(reg_deemph)
      && $stable(reg_readback))
    else $error("read word changed a register");

  all_flag_a: assert property (
    all_silence_flag_o |-> $past(flags) == 6'h3F)
    else $error("combined flag without all channels silent");

  mute_follow_a: assert property (
    silence_mute_enable && (flags != 6'h00) |=>
      (mute_to_midscale_o & $past(flags)) == $past(flags))
    else $error("silent channel not forced to mid-scale");

  sequence next_word_due;
    (state == RD_SEND) && word_tick && more && !frame_end;
  endsequence

  pair_a_write_a: assert property (
    wr_to(`IDX_DEEMPH) |=> dac_cfg_o.deemph_en_pair_a == $past(word.data[0]))
    else $error("pair a de-emphasis enable not stored");

  pair_b_write_a: assert property (
    wr_to(`IDX_DEEMPH) |=> dac_cfg_o.deemph_en_pair_b == $past(word.data[1]))
    else $error("pair b de-emphasis enable not stored");

  pair_c_write_a: assert property (
    wr_to(`IDX_DEEMPH) |=> dac_cfg_o.deemph_en_pair_c == $past(word.data[2]))
    else $error("pair c de-emphasis enable not stored");

  invert_mute_a: assert property (
    dac_cfg_o.output_invert [*3] |-> (mute_to_midscale_o == 6'h00) && !all_silence_flag_o)
    else $error("zero mute still active while inverted");

  index_write_a: assert property (
    wr_to(`IDX_READBACK) |=> {auto_inc, rd_idx} == $past(word.data))
    else $error("read index and auto-increment not stored");

  auto_next_a: assert property (
    next_word_due |=> load && (cur_idx == $past(next_idx))
      && (load_word.word_index_field == $past(next_idx)))
    else $error("auto read did not move to the next register");

  busy_refuse_a: assert property (
    (state == RD_SEND) && word_tick |=> $stable(reg_format) && $stable(reg_gpo)
      && $stable(silence_mute_enable) && $stable(reg_readback))
    else $error("word during read answer changed a register");

  all_flag_set_a: assert property (
    flags == 6'h3F |=> all_silence_flag_o)
    else $error("combined flag missing with all channels silent");

  mute_off_a: assert property (
    !silence_mute_enable |=> mute_to_midscale_o == 6'h00)
    else $error("channel forced to mid-scale with zero mute off");
endmodule

//--- sim/host_ctrl_model.sv
// Purpose: host side of the 4-wire control port, word level tasks
// Assumes: driven from the system clock, half phases of HALF_CYC cycles
// Notes: bit clock idles high and stands still between frames
`timescale 1ns/1ps
module host_ctrl_model
  import dac_cfg_pkg::*;
#(
  parameter int HALF_CYC = 8
)
(
  input  wire logic clk_sys_i,
  input  wire logic ctrl_dout_i,
  output logic      ctrl_sel_b_o,
  output logic      ctrl_clk_o,
  output logic      ctrl_din_o
);
  initial begin
    ctrl_sel_b_o = 1'b1;
    ctrl_clk_o   = 1'b1;
    ctrl_din_o   = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic frame_begin();
    @(posedge clk_sys_i);
    ctrl_sel_b_o <= 1'b0;
    wait_cyc(HALF_CYC);
  endtask
  // data changes on the falling bit clock, answer bit taken at the rising one
  task automatic xfer_word(input ctrl_word_type w, output logic [15:0] r);
    for (int b = 15; b >= 0; b--) begin
      @(posedge clk_sys_i);
      ctrl_clk_o <= 1'b0;
      ctrl_din_o <= w[b];
      wait_cyc(HALF_CYC);
      ctrl_clk_o <= 1'b1;
      r[b] = ctrl_dout_i;
      wait_cyc(HALF_CYC - 1);
    end
  endtask
  // released data line shows the inverse so a stale level is never trusted
  task automatic frame_end();
    @(posedge clk_sys_i);
    ctrl_sel_b_o <= 1'b1;
    ctrl_din_o   <= ~ctrl_din_o;
    wait_cyc(12);
  endtask
endmodule

//--- sim/tb_top.sv
// Purpose: self-checking bench of the DAC control registers
// Assumes: host model drives the control port
// Notes: expectations come from a shadow copy of the written registers
`timescale 1ns/1ps
`include "dac_cfg_defs.svh"
module tb_top
  import dac_cfg_pkg::*;
;
  logic        clk_sys;
  logic        rst_b;
  logic        ctrl_sel_b;
  logic        ctrl_clk;
  logic        ctrl_din;
  logic        ctrl_dout;
  logic        sample_strobe;
  logic [5:0]  sample_zero;
  dac_cfg_type dac_cfg;
  logic [5:0]  gp_pin;
  logic        all_silence_flag;
  logic [5:0]  mute_to_midscale;
  logic [7:0]  shadow [0:127];
  int          fail_count;
  int          total_checks;
  int          seed;

  always #50 clk_sys = ~clk_sys;

  dac_config_registers u_dut (
    .clk_sys_i          (clk_sys),
    .rst_b_i            (rst_b),
    .ctrl_sel_b_i       (ctrl_sel_b),
    .ctrl_clk_i         (ctrl_clk),
    .ctrl_din_i         (ctrl_din),
    .sample_strobe_i    (sample_strobe),
    .sample_zero_i      (sample_zero),
    .ctrl_dout_o        (ctrl_dout),
    .dac_cfg_o          (dac_cfg),
    .gp_pin_o           (gp_pin),
    .all_silence_flag_o (all_silence_flag),
    .mute_to_midscale_o (mute_to_midscale)
  );

  host_ctrl_model u_host (
    .clk_sys_i    (clk_sys),
    .ctrl_dout_i  (ctrl_dout),
    .ctrl_sel_b_o (ctrl_sel_b),
    .ctrl_clk_o   (ctrl_clk),
    .ctrl_din_o   (ctrl_din)
  );

  function automatic logic [7:0] exp_read(input logic [6:0] idx);
    case (idx)
      `IDX_MUTE_CTL: return shadow[idx] & 8'h40;
      `IDX_FORMAT:   return shadow[idx] & 8'h07;
      `IDX_DEEMPH:   return shadow[idx] & 8'h3F;
      `IDX_READBACK,
      `IDX_GPO:      return shadow[idx];
      default:       return 8'h00;
    endcase
  endfunction

  function automatic logic [9:0] exp_cfg();
    return {shadow[9][2:0], shadow[10][4:3], shadow[10][2], shadow[10][1], shadow[10][0],
            shadow[10][5], shadow[12][7]};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    logic [15:0] r;
    u_host.frame_begin();
    u_host.xfer_word({1'b0, idx, d}, r);
    u_host.frame_end();
    shadow[idx] = d;
  endtask

  task automatic check_read(input logic [6:0] idx);
    logic [15:0] ans;
    wr(`IDX_READBACK, {1'b0, idx});
    u_host.frame_begin();
    u_host.xfer_word({1'b1, 7'h55, 8'hA5}, ans);
    u_host.xfer_word(16'h0000, ans);
    u_host.frame_end();
    chk("read", {1'b1, idx, exp_read(idx)}, ans);
  endtask

  task automatic check_pins(input logic [5:0] flags, input logic all_f, input logic [5:0] mute);
    logic [5:0] g;
    g = shadow[12][6] ? shadow[12][5:0] : flags;
    chk("gp_pin", {10'h000, g}, {10'h000, gp_pin});
    chk("all_flag", {15'h0000, all_f}, {15'h0000, all_silence_flag});
    chk("mute", {10'h000, mute}, {10'h000, mute_to_midscale});
  endtask

  task automatic strobes(input int n, input logic [5:0] z);
    repeat (n) begin
      @(posedge clk_sys);
      sample_strobe <= 1'b1;
      sample_zero   <= z;
      @(posedge clk_sys);
      sample_strobe <= 1'b0;
      sample_zero   <= 6'($random(seed));
    end
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    logic [31:0] d;
    logic [15:0] ans;
    logic [2:0]  ch;
    clk_sys       = 1'b0;
    rst_b         = 1'b0;
    sample_strobe = 1'b0;
    sample_zero   = 6'h00;
    seed          = 47157;
    fail_count    = 0;
    total_checks  = 0;
    for (int i = 0; i < 128; i++) shadow[i] = 8'h00;
    shadow[11] = {1'b0, `RD_INDEX_RST};
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("cfg_reset", 16'h0000, {6'h00, dac_cfg});
    check_pins(6'h00, 1'b0, 6'h00);
    u_host.frame_begin();
    u_host.xfer_word({1'b1, 7'h0C, 8'h00}, ans);
    u_host.xfer_word(16'h0000, ans);
    u_host.frame_end();
    chk("read_reset", {1'b1, 7'h01, 8'h00}, ans);
    $display("test reset done");
    // every format and rate code, random remaining bits
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(`IDX_FORMAT, {d[7:3], i[2:0]});
      wr(`IDX_DEEMPH, {d[15:13], i[1:0], d[10:8]});
      wr(`IDX_GPO, d[23:16]);
      chk("cfg", {6'h00, exp_cfg()}, {6'h00, dac_cfg});
      if (!shadow[10][5]) check_pins(6'h00, 1'b0, 6'h00);
      check_read(`IDX_FORMAT);
      check_read(`IDX_DEEMPH);
      check_read(`IDX_GPO);
    end
    wr(7'h20, 8'h5A);
    check_read(7'h20);
    wr(`IDX_MUTE_CTL, 8'hFF);
    check_read(`IDX_MUTE_CTL);
    $display("test write read done");
    wr(`IDX_READBACK, 8'h8C);
    u_host.frame_begin();
    u_host.xfer_word({1'b1, 7'h03, 8'h00}, ans);
    for (int k = 1; k <= 12; k++) begin
      u_host.xfer_word(16'h0000, ans);
      chk("auto_read", {1'b1, k[6:0], exp_read(k[6:0])}, ans);
    end
    u_host.xfer_word(16'h0000, ans);
    chk("auto_stop", 16'h0000, ans);
    u_host.frame_end();
    wr(`IDX_READBACK, 8'h01);
    $display("test auto read done");
    wr(`IDX_DEEMPH, 8'h00);
    wr(`IDX_GPO, 8'h00);
    strobes(1023, 6'h3F);
    check_pins(6'h00, 1'b0, 6'h00);
    strobes(1, 6'h3F);
    check_pins(6'h3F, 1'b1, 6'h3F);
    ch = 3'($unsigned($random(seed)) % 6);
    strobes(1, 6'h3F & ~(6'h01 << ch));
    check_pins(6'h3F & ~(6'h01 << ch), 1'b0, 6'h3F & ~(6'h01 << ch));
    wr(`IDX_MUTE_CTL, 8'h00);
    check_pins(6'h3F & ~(6'h01 << ch), 1'b0, 6'h00);
    wr(`IDX_GPO, 8'h6A);
    check_pins(6'h00, 1'b0, 6'h00);
    wr(`IDX_GPO, 8'h00);
    wr(`IDX_MUTE_CTL, 8'h40);
    wr(`IDX_DEEMPH, 8'h20);
    check_pins(6'h00, 1'b0, 6'h00);
    $display("test zero detect done");
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("cfg_rerun", 16'h0000, {6'h00, dac_cfg});
    check_pins(6'h00, 1'b0, 6'h00);
    u_host.frame_begin();
    u_host.xfer_word({1'b1, 7'h0A, 8'h00}, ans);
    u_host.xfer_word(16'h0000, ans);
    u_host.frame_end();
    chk("read_rerun", {1'b1, 7'h01, 8'h00}, ans);
    $display("test reset rerun done");
    wrap_up();
  end
endmodule
